// >>> rtl/umh_top.sv
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module umh_top
  import umh_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  output logic             req_to_send_n_p1,
  output logic             req_to_send_n_p2,
  output logic             term_ready_n_p1,
  output logic             term_ready_n_p2,
  input  wire logic        rts2_strap_in,
  input  wire logic        clear_to_send_n_p1,
  input  wire logic        clear_to_send_n_p2,
  input  wire logic        set_ready_n_p1,
  input  wire logic        set_ready_n_p2,
  input  wire logic        carrier_detect_n_p1,
  input  wire logic        carrier_detect_n_p2,
  input  wire logic        ring_ind_n_p1,
  input  wire logic        ring_ind_n_p2,
  output logic             ser_out_p1,
  output logic             ser_out_p2,
  input  wire logic        ser_in_p1,
  input  wire logic        ser_in_p2,
  output logic      [15:0] config_base_strap
);

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  umh_aphase_t ap_q;
  umh_aphase_t ap_d;
  wire         take = hsel & hready & htrans[1];
  wire         wr_en = ap_q.valid & ap_q.write;
  wire         rd_en = ap_q.valid & ~ap_q.write;
  wire         sel_p2 = (ap_q.addr & UMH_PORT_STRIDE) != 8'h00;
  wire  [7:0]  reg_ofs = ap_q.addr & ~UMH_PORT_STRIDE;
  wire         strap_hit = ap_q.addr == UMH_STRAP_OFS;

  assign ap_d = '{valid: take, write: hwrite, addr: haddr[7:0]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
    end else begin
      ap_q <= ap_d;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  // Pin is released as an input while reset holds it high; a clocked
  // first-cycle capture avoids loading a port value under async reset.
  logic strap_done_q;
  logic strap_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_q <= 1'b0;
      strap_q      <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      strap_q      <= rts2_strap_in;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_base_strap <= UMH_BASE_LOW;
    end else begin
      config_base_strap <= strap_q ? UMH_BASE_HIGH : UMH_BASE_LOW;
    end
  end

  // ----------------------------------------------------------------
  // Per-port modem logic
  // ----------------------------------------------------------------
  umh_modem_in_t min [2];
  logic [7:0]    mcr_q [2];
  logic [7:0]    ier_q [2];
  logic [3:0]    dflag_q [2];
  umh_modem_in_t prev_q [2];
  logic [7:0]    msr_v [2];
  logic [7:0]    txd_q [2];
  logic [7:0]    rxd_q [2];
  logic [1:0]    ist_q;
  logic [1:0]    ien_q;
  logic [1:0]    rts_n_q;
  logic [1:0]    dtr_n_q;
  logic [1:0]    sout_q;
  logic [1:0]    sin_w;

  assign min[0] = '{cts_n: clear_to_send_n_p1, dsr_n: set_ready_n_p1,
                    ri_n: ring_ind_n_p1, dcd_n: carrier_detect_n_p1};
  assign min[1] = '{cts_n: clear_to_send_n_p2, dsr_n: set_ready_n_p2,
                    ri_n: ring_ind_n_p2, dcd_n: carrier_detect_n_p2};
  assign sin_w = {ser_in_p2, ser_in_p1};

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      wire       me     = sel_p2 == (p == 1);
      wire       wr_mcr = wr_en & me & (reg_ofs == UMH_MCR_OFS);
      wire       wr_ier = wr_en & me & (reg_ofs == UMH_IER_OFS);
      wire       wr_txd = wr_en & me & (reg_ofs == UMH_TXD_OFS);
      wire       rd_msr = rd_en & me & (reg_ofs == UMH_MSR_OFS);
      wire       loop   = mcr_q[p][UMH_MCR_LOOP];
      // Rising edges of the pins are falling edges of the true levels
      wire [3:0] rise   = {~prev_q[p].dcd_n & min[p].dcd_n,
                           ~prev_q[p].ri_n  & min[p].ri_n,
                           ~prev_q[p].dsr_n & min[p].dsr_n,
                           ~prev_q[p].cts_n & min[p].cts_n};
      wire       any_chg = prev_q[p] != min[p];

      assign msr_v[p] = {~min[p].dcd_n, ~min[p].ri_n, ~min[p].dsr_n,
                         ~min[p].cts_n, dflag_q[p]};

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mcr_q[p]   <= UMH_MCR_RST;
          ier_q[p]   <= UMH_IER_RST;
          dflag_q[p] <= 4'h0;
          prev_q[p]  <= '1;
          txd_q[p]   <= 8'h00;
          rxd_q[p]   <= 8'h00;
          rts_n_q[p] <= 1'b1;
          dtr_n_q[p] <= 1'b1;
          sout_q[p]  <= 1'b1;
        end else begin
          prev_q[p] <= min[p];
          if (wr_mcr) mcr_q[p] <= hwdata[7:0];
          if (wr_ier) ier_q[p] <= hwdata[7:0];
          // New edge wins over the read-clear
          dflag_q[p] <= (rd_msr ? 4'h0 : dflag_q[p]) | rise;
          rts_n_q[p] <= loop | ~mcr_q[p][UMH_MCR_RTS];
          dtr_n_q[p] <= loop | ~mcr_q[p][UMH_MCR_DTR];
          // Transmit path ignores clear-to-send entirely
          if (wr_txd) txd_q[p] <= hwdata[7:0];
          sout_q[p]  <= loop ? 1'b1 : txd_q[p][0];
          rxd_q[p]   <= {rxd_q[p][6:0], loop ? sout_q[p] : sin_w[p]};
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ist_q[p] <= 1'b0;
        end else begin
          // Clear by write-one; a change in the same cycle keeps it set when IER bit 3 is on
          ist_q[p] <= (ist_q[p] & ~(wr_en & (ap_q.addr == UMH_ICLR_OFS) & hwdata[p]))
                      | (any_chg & ier_q[p][UMH_IER_MS]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt enable and read mux
  // ----------------------------------------------------------------
  wire ien_wr = wr_en & (ap_q.addr == UMH_IEN_OFS);
  wire ps = sel_p2;
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    if (strap_hit) begin
      rd_d = {16'h0000, config_base_strap};
    end else begin
      case (reg_ofs)
        UMH_MCR_OFS:   rd_d = {24'h000000, mcr_q[ps]};
        UMH_MSR_OFS:   rd_d = {24'h000000, msr_v[ps]};
        UMH_IER_OFS:   rd_d = {24'h000000, ier_q[ps]};
        UMH_ISTAT_OFS: rd_d = ps ? 32'h0000_0000 : {30'h0, ist_q};
        UMH_IEN_OFS:   rd_d = ps ? 32'h0000_0000 : {30'h0, ien_q};
        UMH_TXD_OFS:   rd_d = {24'h000000, txd_q[ps]};
        UMH_RXD_OFS:   rd_d = {24'h000000, rxd_q[ps]};
        default:       rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ien_q  <= UMH_IEN_RST;
      irq    <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      if (ien_wr) ien_q <= hwdata[1:0];
      irq    <= |(ist_q & ien_q);
      hrdata <= take & ~hwrite ? 32'h0000_0000 : (rd_en ? rd_d : 32'h0000_0000);
    end
  end

  // Reads take one wait state: the registered read data needs the edge
  // after the address phase to look up the register before it can stand.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= ~(take & ~hwrite);
    end
  end

  assign hresp = 1'b0;
  assign req_to_send_n_p1 = rts_n_q[0];
  assign req_to_send_n_p2 = rts_n_q[1];
  assign term_ready_n_p1  = dtr_n_q[0];
  assign term_ready_n_p2  = dtr_n_q[1];
  assign ser_out_p1 = sout_q[0];
  assign ser_out_p2 = sout_q[1];

endmodule : umh_top
`default_nettype wire

// >>> rtl/umh_pkg.sv
// Notes on behaviour
// - Request-to-send pin is inverse of control bit 1
// - Terminal-ready pin is inverse of control bit 0
// - Request-to-send pins high during reset
// - Terminal-ready pins high during reset
// - Loopback forces request-to-send pin inactive
// - Loopback forces terminal-ready pin inactive
// - Port-2 request pin strap picks config base
// - Status bit 4 is inverted clear-to-send
// - Bit 0 set on clear-to-send rising edge
// - Status bit 5 is inverted set-ready
// - Bit 1 set on set-ready rising edge
// - Status bit 7 is inverted carrier-detect
// - Bit 3 set on carrier-detect rising edge
// - Enable bit 3 raises interrupt on any change
// - Clear-to-send never gates the transmitter
// - Bit 6 inverted ring, bit 2 its rise
package umh_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses), per port stride
  // ----------------------------------------------------------------
  localparam logic [7:0] UMH_MCR_OFS    = 8'h00;
  localparam logic [7:0] UMH_MSR_OFS    = 8'h04;
  localparam logic [7:0] UMH_IER_OFS    = 8'h08;
  localparam logic [7:0] UMH_ISTAT_OFS  = 8'h0C;
  localparam logic [7:0] UMH_ICLR_OFS   = 8'h10;
  localparam logic [7:0] UMH_IEN_OFS    = 8'h14;
  localparam logic [7:0] UMH_TXD_OFS    = 8'h18;
  localparam logic [7:0] UMH_RXD_OFS    = 8'h1C;
  localparam logic [7:0] UMH_PORT_STRIDE = 8'h20;
  localparam logic [7:0] UMH_STRAP_OFS  = 8'h40;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int UMH_MCR_DTR  = 0;
  localparam int UMH_MCR_RTS  = 1;
  localparam int UMH_MCR_LOOP = 4;
  localparam int UMH_IER_MS   = 3;
  localparam int UMH_MSR_DCTS = 0;
  localparam int UMH_MSR_DDSR = 1;
  localparam int UMH_MSR_DRI  = 2;
  localparam int UMH_MSR_DDCD = 3;
  localparam int UMH_MSR_CTS  = 4;
  localparam int UMH_MSR_DSR  = 5;
  localparam int UMH_MSR_RI   = 6;
  localparam int UMH_MSR_DCD  = 7;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  UMH_MCR_RST   = 8'h00;
  localparam logic [7:0]  UMH_IER_RST   = 8'h00;
  localparam logic [1:0]  UMH_IEN_RST   = 2'h0;
  localparam logic [15:0] UMH_BASE_LOW  = 16'h03F0;
  localparam logic [15:0] UMH_BASE_HIGH = 16'h0370;

  // Modem inputs of one port, active low as on the pins
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic ri_n;
    logic dcd_n;
  } umh_modem_in_t;

  // AHB address phase as captured
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } umh_aphase_t;

endpackage : umh_pkg

// >>> dv/umh_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module umh_modem_model
  import umh_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        ser_out_p1,
  input  wire logic        ser_out_p2,
  output var umh_modem_in_t m1,
  output var umh_modem_in_t m2,
  output var logic         strap,
  output var logic         ser_in_p1,
  output var logic         ser_in_p2
);
  // All handshakes inactive until the bench commands a change
  initial begin
    m1 = '1;
    m2 = '1;
    strap = 1'b0;
    ser_in_p1 = 1'b1;
    ser_in_p2 = 1'b1;
  end
  // Line echo, so the receive pins carry real traffic
  always @(posedge hclk) begin
    ser_in_p1 <= ser_out_p1;
    ser_in_p2 <= ser_out_p2;
  end
  task automatic drive(input logic p, input umh_modem_in_t v);
    @(posedge hclk);
    if (p) m2 <= v;
    else m1 <= v;
  endtask : drive
  // Board level is set while reset is low and then held
  task automatic set_strap(input logic s);
    strap <= s;
  endtask : set_strap
endmodule : umh_modem_model
`default_nettype wire

// >>> dv/umh_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module umh_top_asserts
  import umh_pkg::*;
(
  input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, irq, rts2_strap_in,
  input wire logic [31:0] haddr, hrdata,
  input wire logic [1:0]  htrans,
  input wire logic        req_to_send_n_p1, req_to_send_n_p2, term_ready_n_p1, term_ready_n_p2,
  input wire logic        clear_to_send_n_p1, set_ready_n_p1, ring_ind_n_p1, carrier_detect_n_p1,
  input wire logic [15:0] config_base_strap
);
  logic            wr_q, rd_q;
  wire logic       take = hsel & hready & htrans[1];
  wire logic [3:0] pins = {carrier_detect_n_p1, ring_ind_n_p1, set_ready_n_p1, clear_to_send_n_p1};
  // ------------------------------------------------------------
  // Completing edge of a write, or of a port-1 status read
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (hready) begin
      wr_q <= take & hwrite;
      rd_q <= take & !hwrite & (haddr[7:0] == UMH_MSR_OFS);
    end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_rst_rts_idle: assert property ($rose(hresetn) |-> req_to_send_n_p1 && req_to_send_n_p2)
    else $error("request pin active after reset");
  a_rst_dtr_idle: assert property ($rose(hresetn) |-> term_ready_n_p1 && term_ready_n_p2)
    else $error("ready pin active after reset");
  a_strap_pick: assert property ($rose(hresetn) |-> ##2 config_base_strap ==
    ($past(rts2_strap_in, 2) ? 16'h0370 : 16'h03F0)) else $error("strap base wrong");
  a_strap_hold: assert property ($past(hresetn, 3) |-> $stable(config_base_strap))
    else $error("strap base moved");
  a_rts_by_write: assert property ($changed(req_to_send_n_p1) || $changed(req_to_send_n_p2) |->
    $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3)) else $error("request pin moved unasked");
  a_dtr_by_write: assert property ($changed(term_ready_n_p1) || $changed(term_ready_n_p2) |->
    $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3)) else $error("ready pin moved unasked");
  a_irq_fall_wr: assert property ($fell(irq) |-> $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3))
    else $error("irq dropped unasked");
  a_msr_levels: assert property ($stable(pins)[*5] ##0 (rd_q && hreadyout) |->
    hrdata[7:4] == ~pins) else $error("status levels wrong");
endmodule : umh_top_asserts
`default_nettype wire

// >>> dv/umh_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module umh_top_tb
  import umh_pkg::*;
;
  logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, strap, si1, si2, so1, so2;
  logic [31:0]   haddr, hwdata, hrdata, rd;
  logic [1:0]    htrans, rts_n, dtr_n;
  logic [15:0]   base;
  logic [7:0]    b;
  umh_modem_in_t m1, m2, mv;
  int            bad_count, checks_done, cyc;
  umh_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .req_to_send_n_p1(rts_n[0]),
    .req_to_send_n_p2(rts_n[1]), .term_ready_n_p1(dtr_n[0]), .term_ready_n_p2(dtr_n[1]),
    .rts2_strap_in(strap), .clear_to_send_n_p1(m1.cts_n), .clear_to_send_n_p2(m2.cts_n),
    .set_ready_n_p1(m1.dsr_n), .set_ready_n_p2(m2.dsr_n), .carrier_detect_n_p1(m1.dcd_n),
    .carrier_detect_n_p2(m2.dcd_n), .ring_ind_n_p1(m1.ri_n), .ring_ind_n_p2(m2.ri_n),
    .ser_out_p1(so1), .ser_out_p2(so2), .ser_in_p1(si1), .ser_in_p2(si2),
    .config_base_strap(base));
  umh_modem_model modem (.hclk(hclk), .ser_out_p1(so1), .ser_out_p2(so2), .m1(m1), .m2(m2),
    .strap(strap), .ser_in_p1(si1), .ser_in_p2(si2));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // Bus access and run control
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rchk
  task automatic rst(input logic s);
    modem.set_strap(s);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    `CHK({rts_n, dtr_n}, 4'hF)
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    `CHK(base, s ? 16'h0370 : 16'h03F0)
  endtask : rst
  task automatic summarize();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  initial begin
    hsel = 0; hwrite = 0; htrans = 0; haddr = 0; hwdata = 0; hresetn = 0;
    rst(1'b0);
    xfer(1'b1, 8'h60, 32'hFF);
    rchk(8'h60, 32'h0);
    for (int p = 0; p < 2; p++) begin
      b = p[0] ? UMH_PORT_STRIDE : 8'h00;
      rchk(b + UMH_MCR_OFS, 32'h0);
      for (int v = 0; v < 4; v++) begin
        xfer(1'b1, b + UMH_MCR_OFS, 32'(v));
        repeat (3) @(posedge hclk);
        `CHK({rts_n[p], dtr_n[p]}, ~v[1:0])
      end
      xfer(1'b1, b + UMH_MCR_OFS, 32'h13);
      repeat (3) @(posedge hclk);
      `CHK({rts_n[p], dtr_n[p]}, 2'h3)
      xfer(1'b1, b + UMH_MCR_OFS, 32'h0);
      repeat (3) @(posedge hclk);
      xfer(1'b0, b + UMH_MSR_OFS, 32'h0);
      for (int i = 0; i < 4; i++) begin
        mv = 4'hF;
        mv[i] = 1'b0;
        modem.drive(p[0], mv);
        repeat (3) @(posedge hclk);
        rchk(b + UMH_MSR_OFS, 32'h80 >> i);
        modem.drive(p[0], 4'hF);
        repeat (3) @(posedge hclk);
        rchk(b + UMH_MSR_OFS, 32'h8 >> i);
        rchk(b + UMH_MSR_OFS, 32'h0);
      end
      // Falling clear-to-send sets no status flag yet must interrupt
      xfer(1'b1, b + UMH_IER_OFS, 32'h8);
      rchk(b + UMH_IER_OFS, 32'h8);
      xfer(1'b1, UMH_IEN_OFS, 32'h1 << p);
      modem.drive(p[0], 4'h7);
      repeat (3) @(posedge hclk);
      `CHK(irq, 1'b1)
      xfer(1'b1, UMH_IEN_OFS, 32'h0);
      repeat (3) @(posedge hclk);
      `CHK(irq, 1'b0)
      rchk(UMH_ISTAT_OFS, 32'h1 << p);
      xfer(1'b1, UMH_ICLR_OFS, 32'h1 << p);
      xfer(1'b1, UMH_IEN_OFS, 32'h1 << p);
      repeat (3) @(posedge hclk);
      `CHK(irq, 1'b0)
      xfer(1'b1, b + UMH_IER_OFS, 32'h0);
      modem.drive(p[0], 4'hF);
      repeat (3) @(posedge hclk);
      `CHK(irq, 1'b0)
      xfer(1'b1, b + UMH_TXD_OFS, 32'h1);
      repeat (3) @(posedge hclk);
      `CHK(p[0] ? so2 : so1, 1'b1)
      xfer(1'b1, b + UMH_TXD_OFS, 32'h0);
      repeat (3) @(posedge hclk);
      `CHK(p[0] ? so2 : so1, 1'b0)
    end
    xfer(1'b1, UMH_MCR_OFS, 32'h3);
    repeat (3) @(posedge hclk);
    `CHK({rts_n, dtr_n}, 4'hA)
    rst(1'b1);
    summarize();
  end
endmodule : umh_top_tb
bind umh_top umh_top_asserts u_chk (.*);
`default_nettype wire
